// file: rtl/wdst_cfg.svh
// constants for the supervision watchdog
`ifndef WDST_CFG_SVH
`define WDST_CFG_SVH
`define WDST_CNT_W          16
`define WDST_DIV_SLOW       16384
`define WDST_DIV_FAST       256
`define WDST_PRE_W          14
`define WDST_RELOAD_RST     16'hfffc
`define WDST_SEL_RST        1'b0
`define WDST_WARN_CYCLES    16
`endif

// file: rtl/wdst_pkg.sv
// types for the supervision watchdog
package wdst_pkg;
  typedef enum logic [1:0] {
    WDST_RUN,
    WDST_WARN,
    WDST_RESET
  } wdst_state_t;
endpackage

// file: rtl/wdst_prescaler.sv
// prescaler giving one-cycle tick enables
`timescale 1ns/1ps
`include "wdst_cfg.svh"
module wdst_prescaler #(
  parameter int PRE_W = `WDST_PRE_W
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic clear_in,
  input  wire logic sel_fast_in,
  output logic      tick_out
);
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic             tick_next;
  wire              slow_wrap = (pre_reg == {PRE_W{1'b1}});
  wire              fast_wrap = (pre_reg[7:0] == 8'hff);

  initial begin
    if (PRE_W != 14) $error("prescaler width must be 14");
  end

  assign pre_next  = clear_in ? '0 : (run_in ? pre_reg + 1'b1 : pre_reg);
  assign tick_next = run_in && !clear_in && (sel_fast_in ? fast_wrap : slow_wrap);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pre_reg  <= '0;
      tick_out <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      tick_out <= tick_next;
    end
  end
endmodule

// file: rtl/wdst_watchdog.sv
// supervision watchdog timer top
`timescale 1ns/1ps
`include "wdst_cfg.svh"
module wdst_watchdog
  import wdst_pkg::*;
#(
  parameter int CNT_W       = `WDST_CNT_W,
  parameter int WARN_CYCLES = `WDST_WARN_CYCLES
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             service_in,
  input  wire logic             supervisor_disable_instr_in,
  input  wire logic             supervisor_enable_instr_in,
  input  wire logic [CNT_W-1:0] supervisor_reload_value_in,
  input  wire logic             prescale_fast_in,
  output logic                  prewarn_irq_out,
  output logic                  reset_req_out,
  output logic                  running_out,
  output logic [CNT_W-1:0]      count_out
);
  wdst_state_t      state_reg;
  wdst_state_t      state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             en_reg;
  logic             en_next;
  logic [7:0]       warn_reg;
  logic [7:0]       warn_next;
  logic             tick;
  logic             irq_next;
  logic             rreq_next;

  initial begin
    if (CNT_W != 16) $error("counter width must be 16");
    if (WARN_CYCLES < 1 || WARN_CYCLES > 255) $error("warn cycles out of range");
  end

  function automatic logic is_top(input logic [CNT_W-1:0] v);
    return v == {CNT_W{1'b1}};
  endfunction

  // enable instructions; enable wins when both arrive together
  assign en_next = supervisor_enable_instr_in ? 1'b1 :
                   (supervisor_disable_instr_in ? 1'b0 : en_reg);

  wire run      = en_reg && (state_reg == WDST_RUN);
  wire overflow = run && tick && is_top(cnt_reg);

  wdst_prescaler #(
    .PRE_W (`WDST_PRE_W)
  ) u_pre (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .run_in      (run),
    .clear_in    (service_in),
    .sel_fast_in (prescale_fast_in),
    .tick_out    (tick)
  );

  // load from reload on service and overflow, else count up on tick
  assign cnt_next = (service_in || overflow) ? supervisor_reload_value_in :
                    ((run && tick) ? cnt_reg + 1'b1 : cnt_reg);

  always_comb begin
    state_next = state_reg;
    warn_next  = warn_reg;
    case (state_reg)
      WDST_RUN: begin
        if (overflow) begin
          state_next = WDST_WARN;
          warn_next  = 8'(WARN_CYCLES);
        end
      end
      WDST_WARN: begin
        if (warn_reg == 8'h01) begin
          state_next = WDST_RESET;
        end
        warn_next = warn_reg - 8'h01;
      end
      default: begin
        state_next = WDST_RESET;
      end
    endcase
  end

  assign irq_next  = (state_next == WDST_WARN);
  assign rreq_next = (state_next == WDST_RESET);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg       <= WDST_RUN;
      cnt_reg         <= `WDST_RELOAD_RST;
      en_reg          <= 1'b1;
      warn_reg        <= 8'h00;
      prewarn_irq_out <= 1'b0;
      reset_req_out   <= 1'b0;
      running_out     <= 1'b0;
      count_out       <= '0;
    end else begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      en_reg          <= en_next;
      warn_reg        <= warn_next;
      prewarn_irq_out <= irq_next;
      reset_req_out   <= rreq_next;
      running_out     <= en_next;
      count_out       <= cnt_next;
    end
  end

  sequence seq_warn_then_reset;
    prewarn_irq_out [*2] ##[1:300] reset_req_out;
  endsequence

  AST_START_ENABLED: assert property (@(posedge clk_in)
    $fell(rst_in) |-> en_reg)
    else $error("watchdog not enabled after reset");

  AST_DISABLE_STOPS: assert property (@(posedge clk_in) disable iff (rst_in)
    supervisor_disable_instr_in && !supervisor_enable_instr_in ##1 !supervisor_enable_instr_in
      |=> $stable(cnt_reg) || $past(service_in))
    else $error("counter moved while disabled");

  AST_ENABLE_RESUMES: assert property (@(posedge clk_in) disable iff (rst_in)
    supervisor_enable_instr_in |=> running_out)
    else $error("enable did not resume watchdog");

  AST_OVF_WARN: assert property (@(posedge clk_in) disable iff (rst_in)
    overflow |=> seq_warn_then_reset)
    else $error("overflow did not give prewarning then reset request");

  AST_NO_EARLY_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(reset_req_out) |-> $past(prewarn_irq_out))
    else $error("reset request without prewarning");

  AST_COUNT_STEP: assert property (@(posedge clk_in) disable iff (rst_in)
    run && tick && !service_in && !is_top(cnt_reg) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("counter did not step on tick");

  AST_RELOAD_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    overflow && !service_in |=> cnt_reg == $past(supervisor_reload_value_in))
    else $error("overflow did not load reload value");

  AST_SERVICE: assert property (@(posedge clk_in) disable iff (rst_in)
    service_in |=> cnt_reg == $past(supervisor_reload_value_in) && !tick)
    else $error("service did not reload and clear prescaler");

  AST_FAST_PERIOD: assert property (@(posedge clk_in) disable iff (rst_in)
    tick && prescale_fast_in && run |=> !tick [*8])
    else $error("ticks too close together");
endmodule

// file: sim/wdst_cpu_model.sv
// core model issuing service and supervisor instructions
`timescale 1ns/1ps
module wdst_cpu_model (
  input  wire logic clk_in,
  output logic      service_out,
  output logic      disable_out,
  output logic      enable_out
);
  initial {service_out, disable_out, enable_out} = 3'h0;
  // one-cycle pulse: 0 service, 1 disable, 2 enable
  task automatic issue(input int kind);
    @(posedge clk_in) #1;
    service_out = (kind == 0);
    disable_out = (kind == 1);
    enable_out  = (kind == 2);
    @(posedge clk_in) #1;
    {service_out, disable_out, enable_out} = 3'h0;
  endtask
endmodule

// file: sim/wdst_watchdog_test.sv
// self-checking bench for the supervision watchdog
`timescale 1ns/1ps
module wdst_watchdog_test;
  logic        clk_in, rst_in, fast, svc, dis, en, warn, rreq, run;
  logic [15:0] reload, cnt, held;
  int          bad_count = 0, checks_done = 0, k;
  wdst_cpu_model cpu (.clk_in(clk_in), .service_out(svc), .disable_out(dis), .enable_out(en));
  wdst_watchdog dut (.clk_in(clk_in), .rst_in(rst_in), .service_in(svc),
    .supervisor_disable_instr_in(dis), .supervisor_enable_instr_in(en),
    .supervisor_reload_value_in(reload), .prescale_fast_in(fast),
    .prewarn_irq_out(warn), .reset_req_out(rreq), .running_out(run), .count_out(cnt));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic close_out();
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  initial begin
    #(40000 * 5);
    bad_count++;
    close_out();
  end
  initial begin
    rst_in = 1'b1;
    fast = 1'b1;
    reload = 16'h0000;
    void'($urandom(36364));
    cyc(6);
    rst_in = 1'b0;
    cyc(2);
    chk("running", 1, run);
    chk("count", 16'hfffc, cnt);
    reload = 16'($urandom() & 32'h7fff);
    cpu.issue(0);
    cyc(200);
    cpu.issue(0);
    for (k = 0; k < 3; k++) begin
      cyc(k == 0 ? 126 : 256);
      chk("count", reload + 16'(k), cnt);
    end
    cpu.issue(1);
    cyc(1);
    chk("running", 0, run);
    held = cnt;
    fast = 1'($urandom());
    cyc(600);
    chk("count", held, cnt);
    cpu.issue(2);
    cyc(1);
    chk("running", 1, run);
    fast = 1'b0;
    reload = 16'($urandom() & 32'h7fff);
    cpu.issue(0);
    cyc(16384 - 128);
    chk("count", reload, cnt);
    cyc(256);
    chk("count", reload + 16'h0001, cnt);
    fast = 1'b1;
    reload = 16'hfffe;
    cpu.issue(0);
    k = 0;
    while (warn !== 1'b1 && k < 1000) begin
      cyc(1);
      k++;
    end
    chk("overflow time", 1, k >= 500 && k <= 530);
    chk("reset request", 0, rreq);
    chk("count", reload, cnt);
    k = 0;
    while (warn === 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    chk("prewarn length", 16, 16'(k));
    chk("reset request", 1, rreq);
    rst_in = 1'b1;
    cyc(6);
    rst_in = 1'b0;
    cyc(2);
    chk("reset request", 0, rreq);
    chk("running", 1, run);
    close_out();
  end
endmodule
